// ==== adc_readout_pkg.sv ====
// shared constants and types for the serial readout model
package adc_readout_pkg;
  localparam int RESULT_BITS = 18;
  localparam int SYS_CLK_NS = 10;
  localparam int CONV_MIN_NS = 700;
  localparam int CONV_MAX_NS = 1500;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / SYS_CLK_NS;
  localparam logic [4:0] CS_BUSY_EDGES = 5'h13;
  localparam logic [4:0] CS_PLAIN_EDGES = 5'h12;
  localparam logic [17:0] RESULT_RESET = 18'h00000;
  localparam logic [17:0] SAMPLE_SEED = 18'h2A5C3;

  typedef enum logic [2:0] {
    ST_ACQ = 3'h1,
    ST_CONV = 3'h2,
    ST_SHDN = 3'h4
  } state_t;

  typedef struct packed {
    logic chain;
    logic busy_en;
  } mode_t;

  typedef struct packed {
    logic cnv;
    logic sin;
    logic sck;
  } pins_t;
endpackage : adc_readout_pkg

// ==== pin_sync.sv ====
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ns
module pin_sync
  import adc_readout_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire pins_t pins_in,
  output pins_t level_out,
  output pins_t rise_out,
  output pins_t fall_out
);
  pins_t meta;
  pins_t sync;
  pins_t prev;
  // edges held off until all three stages carry real pin levels, so no false edge follows reset
  logic [2:0] warm;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
      warm <= 3'h0;
    end
    else
    begin
      meta <= pins_in;
      sync <= meta;
      prev <= sync;
      warm <= {warm[1:0], 1'b1};
    end
  end

  assign level_out = sync;
  assign rise_out = warm[2] ? (sync & ~prev) : '0;
  assign fall_out = warm[2] ? (~sync & prev) : '0;
endmodule : pin_sync

// ==== adc_serial_readout.sv ====
// device-side serial readout engine of an 18-bit converter
`timescale 1ns/1ns
module adc_serial_readout
  import adc_readout_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_MAX_CYC,
  parameter logic [17:0] SAMPLE_INIT = SAMPLE_SEED
)
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  // serial pins
  input wire logic CONVERT_START_IN,
  input wire logic SERIAL_IN_IN,
  input wire logic SCLK_IN,
  output logic SERIAL_OUT_OUT,
  output logic SERIAL_OUT_OE_OUT,
  // status
  output logic BUSY_OUT,
  output logic SHUTDOWN_OUT
);
  pins_t lvl;
  pins_t rise;
  pins_t fall;

  pin_sync u_sync (
    .clk_in(CORE_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .pins_in('{cnv: CONVERT_START_IN, sin: SERIAL_IN_IN, sck: SCLK_IN}),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  state_t state;
  state_t next_state;
  mode_t mode;
  mode_t next_mode;
  logic [17:0] shreg;
  logic [17:0] next_shreg;
  logic [4:0] left;
  logic [4:0] next_left;
  logic [4:0] falls;
  logic [4:0] next_falls;
  logic [15:0] conv_cnt;
  logic [15:0] next_conv_cnt;
  logic [17:0] sample;
  logic [17:0] next_sample;
  logic busy_pend;
  logic next_busy_pend;
  logic armed;
  logic next_armed;
  logic serial_out;
  logic next_sdo;
  logic oe;
  logic next_oe;

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_shreg = shreg;
    next_left = left;
    next_falls = falls;
    next_conv_cnt = conv_cnt;
    next_sample = sample;
    next_busy_pend = busy_pend;
    next_armed = armed;
    next_sdo = serial_out;
    next_oe = oe;
    case (state)
      ST_SHDN:
      begin
        if (fall.cnv && !lvl.sck)
          next_state = ST_ACQ;
      end
      ST_CONV:
      begin
        // start pin ignored until the count expires
        next_conv_cnt = conv_cnt + 16'h0001;
        if (conv_cnt == CONV_LAST)
        begin
          next_state = ST_ACQ;
          next_falls = 5'h00;
          next_sample = {sample[16:0], sample[17] ^ sample[10]};
          // unread bits are kept; the new result is loaded into the shift register only when left is zero
          if (left == 5'h00)
          begin
            next_shreg = sample;
            next_left = 5'(RESULT_BITS);
          end
          if (mode.chain)
          begin
            if (mode.busy_en)
            begin
              next_busy_pend = 1'b1;
              next_sdo = 1'b0;
            end
            else
            begin
              next_sdo = (left == 5'h00) ? sample[17] : shreg[17];
            end
          end
          else if (!lvl.cnv || !lvl.sin)
          begin
            next_mode.busy_en = 1'b1;
            next_busy_pend = 1'b1;
            next_armed = 1'b1;
            next_oe = 1'b1;
            next_sdo = 1'b0;
          end
          else
          begin
            next_mode.busy_en = 1'b0;
            next_armed = 1'b0;
          end
        end
      end
      default:
      begin
        if (rise.cnv)
        begin
          next_state = ST_CONV;
          next_conv_cnt = 16'h0000;
          next_mode.chain = !lvl.sin;
          next_mode.busy_en = !lvl.sin && lvl.sck;
          next_busy_pend = 1'b0;
          next_armed = 1'b0;
          next_oe = !lvl.sin;
        end
        else if (fall.cnv && lvl.sck)
        begin
          next_state = ST_SHDN;
          next_oe = mode.chain;
        end
        else if (mode.chain)
        begin
          if (!lvl.cnv && !lvl.sin && left == 5'h00)
            next_sdo = 1'b0;
          if (fall.sck)
          begin
            if (busy_pend)
            begin
              next_busy_pend = 1'b0;
              next_sdo = shreg[17];
            end
            else
            begin
              next_shreg = {shreg[16:0], lvl.sin};
              next_sdo = shreg[16];
              if (left != 5'h00)
                next_left = left - 5'h01;
            end
          end
        end
        else
        begin
          // start low with input low is the forced-low case, not a readout request
          if (!armed && lvl.cnv && !lvl.sin && !mode.busy_en)
          begin
            next_armed = 1'b1;
            next_oe = 1'b1;
            next_sdo = shreg[17];
          end
          else if (!lvl.cnv && !lvl.sin && !armed)
          begin
            next_oe = 1'b1;
            next_sdo = 1'b0;
          end
          if (armed && fall.sck)
          begin
            next_falls = falls + 5'h01;
            if (busy_pend)
            begin
              next_busy_pend = 1'b0;
              next_sdo = shreg[17];
            end
            else
            begin
              next_shreg = {shreg[16:0], 1'b0};
              next_sdo = shreg[16];
              if (left != 5'h00)
                next_left = left - 5'h01;
            end
            if (falls + 5'h01 == (mode.busy_en ? CS_BUSY_EDGES : CS_PLAIN_EDGES))
            begin
              next_oe = 1'b0;
              next_armed = 1'b0;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state <= ST_ACQ;
      mode <= '0;
      shreg <= RESULT_RESET;
      left <= 5'h00;
      falls <= 5'h00;
      conv_cnt <= 16'h0000;
      sample <= SAMPLE_INIT;
      busy_pend <= 1'b0;
      armed <= 1'b0;
      serial_out <= 1'b0;
      oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      shreg <= next_shreg;
      left <= next_left;
      falls <= next_falls;
      conv_cnt <= next_conv_cnt;
      sample <= next_sample;
      busy_pend <= next_busy_pend;
      armed <= next_armed;
      serial_out <= next_sdo;
      oe <= next_oe;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      SERIAL_OUT_OUT <= 1'b0;
      SERIAL_OUT_OE_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
      SHUTDOWN_OUT <= 1'b0;
    end
    else
    begin
      SERIAL_OUT_OUT <= next_sdo;
      SERIAL_OUT_OE_OUT <= next_oe;
      BUSY_OUT <= (next_state == ST_CONV);
      SHUTDOWN_OUT <= (next_state == ST_SHDN);
    end
  end
endmodule : adc_serial_readout

// ==== adc_serial_readout_properties.sv ====
// assertions on the readout pins
`timescale 1ns/1ns
module adc_serial_readout_properties (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  // pins
  input wire logic CONVERT_START_IN,
  input wire logic SERIAL_IN_IN,
  input wire logic SCLK_IN,
  input wire logic SERIAL_OUT_OUT,
  input wire logic SERIAL_OUT_OE_OUT,
  input wire logic BUSY_OUT,
  input wire logic SHUTDOWN_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  AST_FLOAT: assert property (
    $rose(CONVERT_START_IN) && SERIAL_IN_IN && !BUSY_OUT && !SHUTDOWN_OUT
    |-> ##[2:6] !SERIAL_OUT_OE_OUT) else $error("no float");
  AST_START: assert property (
    $rose(CONVERT_START_IN) && !BUSY_OUT && !SHUTDOWN_OUT |-> ##[2:6] BUSY_OUT)
    else $error("no start");
  AST_CONV: assert property (
    $rose(BUSY_OUT) |-> BUSY_OUT[*8] ##1 BUSY_OUT[*8] ##[1:8] !BUSY_OUT)
    else $error("bad conversion length");
  AST_BUSY_LOW: assert property (
    $fell(BUSY_OUT) && !CONVERT_START_IN && SERIAL_IN_IN
    |-> ##[0:2] SERIAL_OUT_OE_OUT && !SERIAL_OUT_OUT) else $error("no busy bit");
  AST_BOTH_LOW: assert property (
    (!CONVERT_START_IN && !SERIAL_IN_IN)[*6] |-> SERIAL_OUT_OE_OUT && !SERIAL_OUT_OUT)
    else $error("output not low");
  AST_SLEEP: assert property (
    $fell(CONVERT_START_IN) && SCLK_IN && !BUSY_OUT |-> ##[2:6] SHUTDOWN_OUT)
    else $error("no shutdown");
  AST_WAKE: assert property (
    $fell(CONVERT_START_IN) && !SCLK_IN && SHUTDOWN_OUT |-> ##[2:6] !SHUTDOWN_OUT)
    else $error("no wake");
  AST_REST: assert property (
    SHUTDOWN_OUT |-> !BUSY_OUT) else $error("busy in shutdown");
  cover property ($fell(BUSY_OUT));
  cover property ($rose(SHUTDOWN_OUT));
  cover property ($rose(SERIAL_OUT_OE_OUT));
endmodule : adc_serial_readout_properties

// ==== adc_host_model.sv ====
// host that clocks the serial link and captures the data line
`timescale 1ns/1ns
module adc_host_model (
  // control
  input wire logic go_in,
  input wire logic [6:0] falls_in,
  input wire logic idle_in,
  // link
  input wire logic sdo_in,
  input wire logic oe_in,
  output logic sclk_out,
  // capture
  output logic [37:0] word_out,
  output logic done_out
);
  logic run = 1'h0;
  logic ph = 1'h1;
  // clock stands at the idle level between frames
  assign sclk_out = run ? ph : idle_in;
  initial word_out = 38'h0;
  initial done_out = 1'h0;
  always @(posedge go_in)
  begin
    done_out = 1'h0;
    #63;
    run = 1'h1;
    repeat (falls_in)
    begin
      ph = 1'h1;
      #40;
      // released line reads high through the pull-up
      word_out = {word_out[36:0], oe_in ? sdo_in : 1'h1};
      ph = 1'h0;
      #40;
    end
    run = 1'h0;
    done_out = 1'h1;
  end
endmodule : adc_host_model

// ==== tb_adc_serial_readout.sv ====
// bench for the serial readout engine
`timescale 1ns/1ns
module tb_adc_serial_readout;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic cnv = 1'h1;
  logic sin = 1'h1;
  logic idle = 1'h0;
  logic go = 1'h0;
  logic [6:0] falls = 7'h00;
  logic sclk, serial_out, oe, busy, shdn, done;
  logic [37:0] word;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  adc_serial_readout #(.CONV_CYCLES(20)) i_adc_serial_readout (
    .CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .CONVERT_START_IN(cnv),
    .SERIAL_IN_IN(sin), .SCLK_IN(sclk), .SERIAL_OUT_OUT(serial_out),
    .SERIAL_OUT_OE_OUT(oe), .BUSY_OUT(busy), .SHUTDOWN_OUT(shdn));
  adc_host_model i_adc_host_model (.go_in(go), .falls_in(falls), .idle_in(idle),
    .sdo_in(serial_out), .oe_in(oe), .sclk_out(sclk), .word_out(word), .done_out(done));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [37:0] seen, input logic [37:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic await(input logic busy_wait);
    int i;
    i = 0;
    while ((busy_wait ? busy !== 1'h0 : done !== 1'h1) && i < 400)
    begin
      tick(1);
      i++;
    end
    if (i == 400)
    begin
      error_cnt++;
      results();
    end
    tick(6);
  endtask : await
  task automatic frame(input logic [6:0] n);
    falls = n;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    await(1'h0);
  endtask : frame
  task automatic sel3_busy();
    cnv = 1'h0;
    tick(6);
    cnv = 1'h1;
    tick(6);
    chk("float", oe, 1'h0);
    cnv = 1'h0;
    tick(4);
    await(1'h1);
    chk("busy bit", {oe, serial_out}, 2'h2);
    frame(7'h12);
    chk("first bit", word[17], 1'h0);
    chk("held", oe, 1'h1);
    frame(7'h01);
    chk("release", oe, 1'h0);
  endtask : sel3_busy
  task automatic sel4(input logic bz);
    cnv = 1'h0;
    tick(8);
    cnv = 1'h1;
    tick(4);
    sin = !bz;
    tick(4);
    await(1'h1);
    chk("end", {oe, serial_out & oe}, {bz, 1'h0});
    sin = 1'h0;
    tick(6);
    chk("msb", oe, 1'h1);
    frame(7'h11);
    chk("17 falls", oe, 1'h1);
    sin = 1'h1;
    cnv = 1'h0;
    tick(8);
    cnv = 1'h1;
    tick(6);
    chk("early", oe, 1'h0);
    await(1'h1);
  endtask : sel4
  task automatic chain(input logic bz);
    sin = 1'h0;
    cnv = 1'h0;
    idle = 1'h0;
    tick(8);
    chk("low", {oe, serial_out}, 2'h2);
    idle = bz;
    tick(4);
    cnv = 1'h1;
    tick(6);
    chk("drive", oe, 1'h1);
    sin = 1'h1;
    await(1'h1);
    if (bz)
      chk("own busy", serial_out, 1'h0);
    frame(bz ? 7'h13 : 7'h12);
    sin = 1'h0;
    frame(7'h12);
    chk("ones", word[17:0], 18'h3FFFF);
    frame(7'h12);
    chk("zeros", word[17:0], 18'h00000);
    chk("still", oe, 1'h1);
    idle = 1'h0;
  endtask : chain
  task automatic sleep();
    sin = 1'h1;
    idle = 1'h1;
    tick(8);
    cnv = 1'h0;
    tick(8);
    chk("sleep", shdn, 1'h1);
    idle = 1'h0;
    tick(8);
    cnv = 1'h1;
    await(1'h1);
    cnv = 1'h0;
    tick(8);
    chk("wake", shdn, 1'h0);
  endtask : sleep
  initial
  begin
    tick(12);
    arst_n = 1'h1;
    tick(4);
    sel3_busy();
    sel4(1'h1);
    sel4(1'h0);
    chain(1'h0);
    chain(1'h1);
    sleep();
    results();
  end
endmodule : tb_adc_serial_readout
bind adc_serial_readout adc_serial_readout_properties i_adc_serial_readout_properties (
  .CORE_CLK_IN(CORE_CLK_IN), .ARST_N_IN(ARST_N_IN), .CONVERT_START_IN(CONVERT_START_IN),
  .SERIAL_IN_IN(SERIAL_IN_IN), .SCLK_IN(SCLK_IN), .SERIAL_OUT_OUT(SERIAL_OUT_OUT),
  .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT), .BUSY_OUT(BUSY_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT));
